// ===== src/sfb_pkg.sv
/*
  Package for the special function register bank: offsets, reset values,
  field positions and the bus carrier structs.
  Assumes a 32-bit AXI4-Lite master; register index times four is the byte address.
*/
package sfb_pkg;
  // Register indices (byte address = index * 4)
  localparam logic [7:0] IDX_STACK = 8'h81;
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
  localparam logic [7:0] IDX_TCTRL = 8'h88;
  localparam logic [7:0] IDX_TMODE = 8'h89;
  localparam logic [7:0] IDX_TL0 = 8'h8A;
  localparam logic [7:0] IDX_TL1 = 8'h8B;
  localparam logic [7:0] IDX_TH0 = 8'h8C;
  localparam logic [7:0] IDX_TH1 = 8'h8D;
  localparam logic [7:0] IDX_TAUX = 8'h8F;
  localparam logic [7:0] IDX_TRIM = 8'h96;
  localparam logic [7:0] IDX_SCTRL = 8'h98;
  localparam logic [7:0] IDX_SERIAL_BUFFER_REG = 8'h99;
  localparam logic [7:0] IDX_WDCTL = 8'hA7;
  localparam logic [7:0] IDX_SADR = 8'hA9;
  localparam logic [7:0] IDX_APWR = 8'hB5;
  localparam logic [7:0] IDX_SMSK = 8'hB9;
  localparam logic [7:0] IDX_SEXT = 8'hBA;
  localparam logic [7:0] IDX_WDLD = 8'hC1;
  localparam logic [7:0] IDX_WSV1 = 8'hC2;
  localparam logic [7:0] IDX_WSV2 = 8'hC3;
  localparam logic [7:0] IDX_PRLO = 8'hCA;
  localparam logic [7:0] IDX_PRHI = 8'hCB;
  localparam logic [7:0] IDX_CPSW = 8'hD0;
  localparam logic [7:0] IDX_RTCC = 8'hD1;
  localparam logic [7:0] IDX_RTC_COUNT_HIGH = 8'hD2;
  localparam logic [7:0] IDX_RTC_COUNT_LOW = 8'hD3;
  localparam logic [7:0] IDX_RCAUSE = 8'hDF;
  localparam logic [7:0] IDX_SPIST = 8'hE1;
  localparam logic [7:0] IDX_SPICT = 8'hE2;
  localparam logic [7:0] IDX_SPIDT = 8'hE3;
  localparam logic [7:0] IDX_P0DIS = 8'hF6;
  // Own registers: reset-event control, port configuration status and machine cycle phase
  localparam logic [7:0] IDX_RSTCMD = 8'hFC;
  localparam logic [7:0] IDX_PINCFG = 8'hFD;
  localparam logic [7:0] IDX_MCYC = 8'hFE;
  // Reset values
  localparam logic [7:0] RST_STACK = 8'h07;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_WDLD = 8'hFF;
  localparam logic [7:0] RST_RTCC = 8'h60;
  localparam logic [7:0] RST_SPICT = 8'h04;
  localparam logic [7:0] RST_RCAUSE_POR = 8'h30;
  localparam logic [7:0] RST_WDCTL = 8'hE5;
  localparam logic [7:0] RST_PIN_INPUT = 8'hFF;
  // Implemented-bit masks for partially reserved registers
  localparam logic [7:0] MSK_TAUX = 8'h11;
  localparam logic [7:0] MSK_PRHI = 8'h03;
  localparam logic [7:0] MSK_P0DIS = 8'h3E;
  localparam logic [7:0] MSK_APWR = 8'hBE;
  localparam logic [7:0] MSK_RTCC = 8'hE3;
  localparam logic [7:0] MSK_SPIST = 8'hC0;
  localparam logic [7:0] MSK_WDCTL = 8'hE7;
  localparam logic [7:0] MSK_RCAUSE = 8'h3F;
  // Field positions
  localparam int WD_TOF_BIT = 1;
  localparam int RC_BROWNOUT = 5;
  localparam int RC_POWERON = 4;
  localparam int RC_BREAK = 3;
  localparam int RC_WATCHDOG = 2;
  localparam int RC_SOFTWARE = 1;
  localparam int RC_EXTERNAL = 0;
  localparam int CMD_SW_RESET_BIT = 0;
  // CPU clocks per machine cycle
  localparam int CLK_PER_MCYC = 2;
  // Factory trim default (arbitrary)
  localparam logic [7:0] TRIM_FACTORY_DEF = 8'h20;

  // Reset source kinds from the reset generator
  typedef enum logic [2:0]
  {
    SRC_NONE = 3'h0,
    SRC_POWERON = 3'h1,
    SRC_BROWNOUT = 3'h2,
    SRC_BREAK = 3'h3,
    SRC_WATCHDOG = 3'h4,
    SRC_SOFTWARE = 3'h5,
    SRC_EXTERNAL = 3'h6
  } sfb_src_e;

  typedef struct packed
  {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } sfb_axi_req_s;

  typedef struct packed
  {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sfb_axi_rsp_s;
endpackage

// ===== src/sfb_bank.sv
/*
  Special function register bank with per-source reset initialisation.
  Assumes a reset generator that pulses i_rst_event with the cause of a warm
  reset, and that i_rst_n is the power-on reset alone.
*/
`timescale 1ns/1ns
// Summary of operation
// R1 - Power-up reset sets power-on and brownout flags, clears others: cause reads 30.
// R2 - Cause register records latest reset source in bits 5..0.
// R3 - RTC control, RTC counts, trim, watchdog control initialised by power-on only.
// R4 - Trim loads factory value on power-on; other resets leave it.
// R5 - Watchdog control reads 1110 01x1 after reset.
// R6 - Watchdog timeout flag: 1 after watchdog reset, 0 after power-on, else kept.
// R7 - Software writes baud divisors only while baud generator is disabled.
// R8 - All port pins input-only after power-up.
// R9 - Machine cycle lasts two CPU clocks.
// R10 - Timer control at 88H holds overflow, run and external interrupt bits; resets 00.
// R11 - Timer aux mode at 8FH implements bits 4 and 0 only; resets 00.
// R12 - Prescaler low 8 bits at CAH, high bits 1..0 at CBH; both reset 00.
// R13 - Port0 input disable at F6H implements bits 5..1; resets 00.
// R14 - Aux power control at B5H has bits 7,5,4,3,2,1; resets 00.
// R15 - Trim at 96H: RC select bit7, clock out bit6, trim bits 5..0.
// R16 - Serial extended status at BAH holds eight listed bits; resets 00.
// R17 - Serial buffer has no defined reset value.
// R18 - Status word, serial control, timer control are bit addressable.
// R19 - Reserved bits ignore writes and read as zero.
module sfb_bank
  import sfb_pkg::*;
(
  // Clock and power-on reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Warm reset events from the reset generator (same clock)
  input wire logic i_rst_event,
  input wire sfb_pkg::sfb_src_e i_rst_src,
  // Factory trim value, sampled after power-on release
  input wire logic [7:0] i_factory_trim,
  // Core bit-addressed access
  input wire logic i_bit_we,
  input wire logic [7:0] i_bit_addr,
  input wire logic i_bit_val,
  // AXI4-Lite slave
  input wire sfb_pkg::sfb_axi_req_s i_axi,
  output sfb_pkg::sfb_axi_rsp_s o_axi,
  // Block outputs
  output logic o_mcyc_strobe,
  output logic [7:0] o_pin_input_only,
  output logic o_sw_reset_req,
  output logic [7:0] o_trim,
  output logic [7:0] o_wd_ctrl
);
  import sfb_pkg::*;

  logic [7:0] regs_r [0:255];
  logic [255:0] warm_r;
  logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
  logic [31:0] awaddr_r, wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic bresp_err_r, rresp_err_r;
  logic trim_load_r, mcyc_r;
  logic [7:0] pin_r;
  logic do_wr, ok_wr, ok_rd;
  logic [7:0] widx, ridx, wval;

  // Implemented-bit mask per register; zero for unmapped
  function automatic logic [7:0] imp_mask(input logic [7:0] idx);
    case (idx)
      IDX_STACK, IDX_POWER_CONTROL, IDX_TCTRL, IDX_TMODE, IDX_TL0, IDX_TL1, IDX_TH0, IDX_TH1,
      IDX_TRIM, IDX_SCTRL, IDX_SERIAL_BUFFER_REG, IDX_SADR, IDX_SMSK, IDX_SEXT, IDX_WDLD,
      IDX_WSV1, IDX_WSV2, IDX_PRLO, IDX_CPSW, IDX_RTC_COUNT_HIGH, IDX_RTC_COUNT_LOW, IDX_SPICT,
      IDX_SPIDT, IDX_RSTCMD: imp_mask = 8'hFF;
      IDX_TAUX: imp_mask = MSK_TAUX;     // [R11]
      IDX_PRHI: imp_mask = MSK_PRHI;     // [R12]
      IDX_P0DIS: imp_mask = MSK_P0DIS;   // [R13]
      IDX_APWR: imp_mask = MSK_APWR;     // [R14]
      IDX_RTCC: imp_mask = MSK_RTCC;
      IDX_SPIST: imp_mask = MSK_SPIST;
      IDX_WDCTL: imp_mask = MSK_WDCTL;
      IDX_RCAUSE: imp_mask = MSK_RCAUSE;
      IDX_PINCFG, IDX_MCYC: imp_mask = 8'h00;
      default: imp_mask = 8'h00;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] idx);
    mapped = (imp_mask(idx) != 8'h00) || idx == IDX_PINCFG || idx == IDX_MCYC;
  endfunction

  // Registers that the warm-reset reload loop skips; power-on reloads them whole, and each warm reset with a cause rewrites the cause register
  function automatic logic por_only(input logic [7:0] idx);
    por_only = idx == IDX_RTCC || idx == IDX_RTC_COUNT_HIGH || idx == IDX_RTC_COUNT_LOW
      || idx == IDX_TRIM || idx == IDX_WDCTL || idx == IDX_RCAUSE; // [R3]
  endfunction

  function automatic logic [7:0] rst_val(input logic [7:0] idx);
    case (idx)
      IDX_STACK: rst_val = RST_STACK;
      IDX_WDLD: rst_val = RST_WDLD;
      IDX_SPICT: rst_val = RST_SPICT;
      default: rst_val = RST_ZERO;
    endcase
  endfunction

  // Write address and data are taken independently, in either order
  assign do_wr = aw_held_r && w_held_r && !bvalid_r;
  assign widx = awaddr_r[9:2];
  assign ok_wr = mapped(widx) && awaddr_r[31:10] == 22'h0 && widx != IDX_PINCFG
    && widx != IDX_MCYC && widx != IDX_RCAUSE;
  assign wval = (regs_r[widx] & ~imp_mask(widx)) | (wdata_r[7:0] & imp_mask(widx)); // [R19]
  assign ridx = i_axi.araddr[9:2];
  assign ok_rd = mapped(ridx) && i_axi.araddr[31:10] == 22'h0;

  always_comb
  begin
    o_axi.awready = !aw_held_r;
    o_axi.wready = !w_held_r;
    o_axi.bvalid = bvalid_r;
    o_axi.bresp = bresp_err_r ? 2'h2 : 2'h0;
    o_axi.arready = !rvalid_r;
    o_axi.rvalid = rvalid_r;
    o_axi.rdata = rdata_r;
    o_axi.rresp = rresp_err_r ? 2'h2 : 2'h0;
  end

  // Write channel capture and response
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_err_r <= 1'b0;
      awaddr_r <= 32'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end
    else
    begin
      if (i_axi.awvalid && !aw_held_r)
      begin
        aw_held_r <= 1'b1;
        awaddr_r <= i_axi.awaddr;
      end
      if (i_axi.wvalid && !w_held_r)
      begin
        w_held_r <= 1'b1;
        wdata_r <= i_axi.wdata;
        wstrb_r <= i_axi.wstrb;
      end
      if (do_wr)
      begin
        bvalid_r <= 1'b1;
        bresp_err_r <= !ok_wr;
      end
      else if (bvalid_r && i_axi.bready)
      begin
        bvalid_r <= 1'b0;
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
      end
    end
  end

  // Read channel: one cycle from address to data, reserved bits read zero
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_err_r <= 1'b0;
    end
    else if (i_axi.arvalid && !rvalid_r)
    begin
      rvalid_r <= 1'b1;
      rresp_err_r <= !ok_rd;
      if (ridx == IDX_PINCFG)
        rdata_r <= {24'h0, pin_r};
      else if (ridx == IDX_MCYC)
        rdata_r <= {31'h0, mcyc_r};
      else
        rdata_r <= {24'h0, regs_r[ridx] & imp_mask(ridx)}; // [R19]
    end
    else if (rvalid_r && i_axi.rready)
      rvalid_r <= 1'b0;
  end

  // Which registers each warm reset must reinitialise, fixed by the POR-only list
  always_comb
  begin
    for (int i = 0; i < 256; i++)
      warm_r[i] = !por_only(8'(i));
  end

  // Register array: power-on resets all, warm reset resets non-POR-only ones except the serial buffer
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < 256; i++)
        regs_r[i] <= RST_ZERO;
      regs_r[IDX_STACK] <= RST_STACK;
      regs_r[IDX_WDLD] <= RST_WDLD;
      regs_r[IDX_SPICT] <= RST_SPICT;
      regs_r[IDX_RTCC] <= RST_RTCC;            // [R3]
      regs_r[IDX_WDCTL] <= RST_WDCTL & ~(8'h1 << WD_TOF_BIT); // [R5] [R6]
      regs_r[IDX_RCAUSE] <= RST_RCAUSE_POR;    // [R1]
      regs_r[IDX_SERIAL_BUFFER_REG] <= RST_ZERO;            // Arbitrary, no defined value [R17]
    end
    else if (trim_load_r)
      regs_r[IDX_TRIM] <= i_factory_trim;      // [R4] [R15]
    else if (i_rst_event)
    begin
      for (int i = 0; i < 256; i++)
        if (warm_r[i] && i != int'(IDX_SERIAL_BUFFER_REG))  // Buffer keeps its content [R17]
          regs_r[i] <= rst_val(8'(i));         // [R3]
      // Watchdog control keeps its bits through warm resets, only the timeout
      // flag follows a watchdog cause; a signalled power-on reloads the POR-only set
      if (i_rst_src == SRC_POWERON)
      begin
        regs_r[IDX_WDCTL] <= RST_WDCTL & ~(8'h1 << WD_TOF_BIT); // [R5] [R6]
        regs_r[IDX_TRIM] <= i_factory_trim;    // [R4]
        regs_r[IDX_RTCC] <= RST_RTCC;          // [R3]
        regs_r[IDX_RTC_COUNT_HIGH] <= RST_ZERO;
        regs_r[IDX_RTC_COUNT_LOW] <= RST_ZERO;
      end
      else if (i_rst_src == SRC_WATCHDOG)
        regs_r[IDX_WDCTL] <= regs_r[IDX_WDCTL] | (8'h1 << WD_TOF_BIT); // [R3] [R6]
      case (i_rst_src)
        SRC_POWERON: regs_r[IDX_RCAUSE] <= RST_RCAUSE_POR; // [R1]
        SRC_BROWNOUT: regs_r[IDX_RCAUSE] <= 8'(1 << RC_BROWNOUT); // [R2]
        SRC_BREAK: regs_r[IDX_RCAUSE] <= 8'(1 << RC_BREAK);
        SRC_WATCHDOG: regs_r[IDX_RCAUSE] <= 8'(1 << RC_WATCHDOG);
        SRC_SOFTWARE: regs_r[IDX_RCAUSE] <= 8'(1 << RC_SOFTWARE);
        SRC_EXTERNAL: regs_r[IDX_RCAUSE] <= 8'(1 << RC_EXTERNAL);
        default: regs_r[IDX_RCAUSE] <= regs_r[IDX_RCAUSE];
      endcase
    end
    else if (do_wr && ok_wr && wstrb_r[0])
      regs_r[widx] <= wval;
    else if (i_bit_we && i_bit_addr[7] && (i_bit_addr[7:3] == 5'b10001
      || i_bit_addr[7:3] == 5'b10011 || i_bit_addr[7:3] == 5'b11010))
      // Bit address = register base + bit position [R18]
      regs_r[{i_bit_addr[7:3], 3'b000}][i_bit_addr[2:0]] <= i_bit_val;
  end

  // Factory trim is caught one clock after power-on release, and later only on a signalled power-on [R4]
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      trim_load_r <= 1'b1;
    else
      trim_load_r <= 1'b0;
  end

  // Port pins stay input-only from power-up; a warm reset does not change them [R8]
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      pin_r <= RST_PIN_INPUT;
    else
      pin_r <= pin_r;
  end

  // Machine cycle phase: toggles every clock, two clocks per cycle [R9]
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      mcyc_r <= 1'b0;
    else
      mcyc_r <= 1'(int'(mcyc_r) + 1 < CLK_PER_MCYC ? 1 : 0);
  end

  // Software reset request: a pulse when the command bit is written
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_sw_reset_req <= 1'b0;
    else
      o_sw_reset_req <= do_wr && ok_wr && widx == IDX_RSTCMD && wdata_r[CMD_SW_RESET_BIT];
  end

  assign o_mcyc_strobe = mcyc_r;
  assign o_pin_input_only = pin_r;
  assign o_trim = regs_r[IDX_TRIM];
  assign o_wd_ctrl = regs_r[IDX_WDCTL] & MSK_WDCTL;

  // The baud divisors live in the serial block; software keeps them
  // untouched while that generator runs. [R7]
  // Timer control and serial extended status layouts follow the register map bit order. [R10] [R16]
endmodule

// ===== sim/sfb_bank_asserts.sv
/*
  Port checker for the register bank.
  Assumes one clock domain and the power-on reset on i_rst_n.
*/
`timescale 1ns/1ns
module sfb_bank_chk
  import sfb_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Watched inputs
  input wire logic i_rst_event,
  input wire sfb_pkg::sfb_src_e i_rst_src,
  input wire logic [7:0] i_factory_trim,
  input wire sfb_pkg::sfb_axi_req_s i_axi,
  // Watched outputs
  input wire sfb_pkg::sfb_axi_rsp_s o_axi,
  input wire logic o_mcyc_strobe,
  input wire logic [7:0] o_pin_input_only,
  input wire logic [7:0] o_trim,
  input wire logic [7:0] o_wd_ctrl
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Reset steps seen at the ports
  sequence s_por_exit;
    $rose(i_rst_n);
  endsequence
  // Warm resets other than a signalled power-on, which must leave the trim alone
  sequence s_warm;
    i_rst_event && i_rst_src != SRC_POWERON;
  endsequence
  sequence s_keep_evt;
    i_rst_event && i_rst_src != SRC_POWERON && i_rst_src != SRC_WATCHDOG;
  endsequence
  sequence s_wd_evt;
    i_rst_event && i_rst_src == SRC_WATCHDOG;
  endsequence
  sequence s_ar_take;
    i_axi.arvalid && o_axi.arready;
  endsequence
  property p_mcyc;
    i_rst_n |=> o_mcyc_strobe != $past(o_mcyc_strobe);
  endproperty
  property p_pins;
    o_pin_input_only == 8'hFF;
  endproperty
  property p_trim_load;
    s_por_exit |-> ##[1:2] o_trim == i_factory_trim;
  endproperty
  property p_trim_keep;
    s_warm |=> $stable(o_trim);
  endproperty
  property p_wd_por;
    s_por_exit |-> o_wd_ctrl == 8'hE5;
  endproperty
  property p_wd_tof;
    s_wd_evt |=> o_wd_ctrl[WD_TOF_BIT];
  endproperty
  // Warm resets of other kinds leave the whole watchdog control as it was
  property p_wd_keep;
    s_keep_evt |=> $stable(o_wd_ctrl);
  endproperty
  property p_rd_lat;
    s_ar_take |=> o_axi.rvalid;
  endproperty
  a_mcyc: assert property (p_mcyc) else $error("phase did not toggle");
  a_pins: assert property (p_pins) else $error("pin not input-only");
  a_trim_load: assert property (p_trim_load) else $error("trim not loaded");
  a_trim_keep: assert property (p_trim_keep) else $error("trim changed");
  a_wd_por: assert property (p_wd_por) else $error("watchdog ctrl bad");
  a_wd_tof: assert property (p_wd_tof) else $error("timeout flag clear");
  a_wd_keep: assert property (p_wd_keep) else $error("watchdog ctrl changed");
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
endmodule
bind sfb_bank sfb_bank_chk sfb_bank_chk_inst (.i_clk, .i_rst_n, .i_rst_event, .i_rst_src,
  .i_factory_trim, .i_axi, .o_axi, .o_mcyc_strobe, .o_pin_input_only, .o_trim, .o_wd_ctrl);

// ===== sim/sfb_core_model.sv
/*
  Core-side model: the processor's register-bus master.
  Assumes the bank's AXI4-Lite slave on the same clock.
*/
`timescale 1ns/1ns
module sfb_core_model
  import sfb_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Bus response and request
  input wire sfb_pkg::sfb_axi_rsp_s i_rsp,
  output sfb_pkg::sfb_axi_req_s o_req
);
  // Idle bus from time zero so no stray request is seen
  initial o_req = '0;
  // Address and data offered together, each dropped once taken.
  // No divisor register is written here, so none while the generator runs
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r);
    @(posedge i_clk);
    o_req.awvalid <= 1'h1;
    o_req.awaddr <= {22'h0, idx, 2'h0};
    o_req.wvalid <= 1'h1;
    o_req.wdata <= {24'h0, d};
    o_req.wstrb <= 4'h1;
    o_req.bready <= 1'h1;
    do
    begin
      @(posedge i_clk);
      if (i_rsp.awready && o_req.awvalid)
        o_req.awvalid <= 1'h0;
      if (i_rsp.wready && o_req.wvalid)
        o_req.wvalid <= 1'h0;
    end
    while (!i_rsp.bvalid);
    o_req.bready <= 1'h0;
    r = i_rsp.bresp;
  endtask
  // Read: rready held up until the data arrives
  task automatic rd(input logic [7:0] idx, output logic [7:0] d, output logic [1:0] r);
    @(posedge i_clk);
    o_req.arvalid <= 1'h1;
    o_req.araddr <= {22'h0, idx, 2'h0};
    o_req.rready <= 1'h1;
    do
    begin
      @(posedge i_clk);
      if (i_rsp.arready && o_req.arvalid)
        o_req.arvalid <= 1'h0;
    end
    while (!i_rsp.rvalid);
    o_req.rready <= 1'h0;
    d = i_rsp.rdata[7:0];
    r = i_rsp.rresp;
  endtask
endmodule

// ===== sim/testbench.sv
/*
  Self-checking bench for the register bank.
  Assumes the core model as bus master and a 25 MHz clock.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module testbench;
  import sfb_pkg::*;
  logic i_clk = 1'h0;
  logic i_rst_n = 1'h0;
  logic i_rst_event = 1'h0;
  sfb_src_e i_rst_src = SRC_NONE;
  logic [7:0] i_factory_trim = 8'h2A;
  logic i_bit_we = 1'h0;
  logic [7:0] i_bit_addr = 8'h00;
  logic i_bit_val = 1'h0;
  sfb_axi_req_s axi_req;
  sfb_axi_rsp_s axi_rsp;
  logic o_mcyc_strobe;
  logic swreq;
  logic [7:0] pins;
  logic [7:0] trim;
  logic [7:0] wdc;
  logic [7:0] rdv;
  logic [1:0] resp;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int swcnt = 0;
  // Tables: reset values, masked writes of all ones, warm reset sources
  logic [7:0] rv_i [15] = '{IDX_STACK, IDX_POWER_CONTROL, IDX_TCTRL, IDX_TAUX, IDX_PRLO, IDX_PRHI,
    IDX_P0DIS, IDX_APWR, IDX_SEXT, IDX_WDLD, IDX_RTCC, IDX_SPICT, IDX_RCAUSE, IDX_WDCTL,
    IDX_TRIM};
  logic [7:0] rv_v [15] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hFF, 8'h60, 8'h04, 8'h30, 8'hE5, 8'h2A};
  logic [7:0] mw_i [8] = '{IDX_TAUX, IDX_PRHI, IDX_P0DIS, IDX_APWR, IDX_SEXT, IDX_PRLO,
    IDX_TRIM, IDX_TCTRL};
  logic [7:0] mw_v [8] = '{8'h11, 8'h03, 8'h3E, 8'hBE, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  sfb_src_e ws [6] = '{SRC_BROWNOUT, SRC_WATCHDOG, SRC_BREAK, SRC_SOFTWARE, SRC_EXTERNAL,
    SRC_POWERON};
  logic [7:0] wc [6] = '{8'h20, 8'h04, 8'h08, 8'h02, 8'h01, 8'h30};
  logic [7:0] wt [6] = '{8'h60, 8'h62, 8'h62, 8'h62, 8'h62, 8'hE5};
  logic [7:0] tt [6] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h2A};
  logic [7:0] ba [3] = '{8'h8B, 8'hD7, 8'h98};
  logic [7:0] bi [3] = '{IDX_TCTRL, IDX_CPSW, IDX_SCTRL};
  logic [7:0] bv [3] = '{8'h08, 8'h80, 8'h01};

  // 40 ns period
  always #20 i_clk = ~i_clk;

  sfb_bank sfb_bank_inst (.i_clk, .i_rst_n, .i_rst_event, .i_rst_src, .i_factory_trim,
    .i_bit_we, .i_bit_addr, .i_bit_val, .i_axi(axi_req), .o_axi(axi_rsp), .o_mcyc_strobe,
    .o_pin_input_only(pins), .o_sw_reset_req(swreq), .o_trim(trim), .o_wd_ctrl(wdc));
  sfb_core_model core_inst (.i_clk, .i_rsp(axi_rsp), .o_req(axi_req));

  // Counts software reset request pulses, one per clock edge seen high
  always @(posedge i_clk)
  begin
    if (swreq)
      swcnt++;
  end

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    core_inst.rd(idx, rdv, resp);
    `CHK(resp, 2'h0)
    `CHK(rdv, exp)
  endtask
  task automatic t_reset();
    for (int i = 0; i < 15; i++)
      rdchk(rv_i[i], rv_v[i]);
  endtask
  // Reserved bits must drop out of an all-ones write
  task automatic t_reserved();
    for (int i = 0; i < 8; i++)
    begin
      core_inst.wr(mw_i[i], 8'hFF, resp);
      rdchk(mw_i[i], mw_v[i]);
    end
    `CHK(trim, 8'hFF)
  endtask
  // Brownout first so the timeout flag is seen both clear and kept;
  // watchdog control is preset so a warm reset that reloads it shows up
  task automatic t_warm();
    core_inst.wr(IDX_WDCTL, 8'h60, resp);
    `CHK(resp, 2'h0)
    for (int i = 0; i < 6; i++)
    begin
      @(posedge i_clk);
      i_rst_event <= 1'h1;
      i_rst_src <= ws[i];
      @(posedge i_clk);
      i_rst_event <= 1'h0;
      rdchk(IDX_RCAUSE, wc[i]);
      rdchk(IDX_WDCTL, wt[i]);
      rdchk(IDX_TRIM, tt[i]);
      rdchk(IDX_TCTRL, 8'h00);
      rdchk(IDX_TAUX, 8'h00);
    end
  endtask
  task automatic t_bits();
    for (int i = 0; i < 3; i++)
    begin
      @(posedge i_clk);
      i_bit_we <= 1'h1;
      i_bit_addr <= ba[i];
      i_bit_val <= 1'h1;
      @(posedge i_clk);
      i_bit_we <= 1'h0;
      rdchk(bi[i], bv[i]);
    end
  endtask
  // Unmapped read and a write to the read-only cause register are refused
  task automatic t_err();
    core_inst.rd(8'h00, rdv, resp);
    `CHK(resp, 2'h2)
    core_inst.wr(IDX_RCAUSE, 8'hFF, resp);
    `CHK(resp, 2'h2)
    rdchk(IDX_RCAUSE, 8'h30);
    rdchk(IDX_PINCFG, 8'hFF);
    // Only a write with the command bit set may ask for a software reset
    core_inst.wr(IDX_RSTCMD, 8'h00, resp);
    core_inst.wr(IDX_RSTCMD, 8'h01, resp);
    repeat (2) @(posedge i_clk);
    `CHK(swcnt, 1)
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'h1;
    repeat (2) @(posedge i_clk);
    `CHK(pins, 8'hFF)
    t_reset();
    t_reserved();
    t_warm();
    t_bits();
    t_err();
    report_and_stop();
  end
endmodule
